// [indicator_status_pkg.sv]
// Constants, types and reset values of the indicator status monitor.
// Assumes a single 100 MHz clock and an asynchronous active-low reset.
package indicator_status_pkg;
  localparam int NUM_IND = 5;
  localparam int NUM_DI  = 8;
  localparam int NUM_SW  = 8;
  localparam int SRC_W   = 4;
  localparam int KIND_N  = 4;
  localparam int EVT_W   = NUM_IND * KIND_N;
  localparam int NAME_LEN = 32;
  localparam int CHAR_W  = 8;
  localparam int STAMP_W = 32;
  localparam int IND_W   = 3;
  localparam int POS_W   = 5;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int STAMP_RES_MS  = 1;
  localparam int NS_PER_MS     = 1000000;
  localparam int STAMP_CYCLES  =
    (STAMP_RES_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W = $clog2(STAMP_CYCLES);
  // ------------------------------------------------------------
  // Reset values and encodings
  // ------------------------------------------------------------
  localparam logic [SRC_W-1:0] RST_SEL  = 4'h0;
  localparam logic [EVT_W-1:0] RST_KEEP = 20'hFFFFF;
  localparam logic [7:0] CH_I      = 8'h49;
  localparam logic [7:0] CH_N      = 8'h6E;
  localparam logic [7:0] CH_D      = 8'h64;
  localparam logic [7:0] CH_DIGIT0 = 8'h30;
  typedef enum logic [1:0] {ST_INTER, ST_OPEN, ST_CLOSED, ST_BAD} ind_state_t;
  typedef logic [NUM_IND-1:0][NAME_LEN-1:0][CHAR_W-1:0] name_array_t;
  function automatic name_array_t default_names();
    name_array_t n;
    n = '0;
    for (int i = 0; i < NUM_IND; i++) begin
      n[i][0] = CH_I;
      n[i][1] = CH_N;
      n[i][2] = CH_D;
      n[i][3] = 8'(CH_DIGIT0 + i + 1);
    end
    return n;
  endfunction
  localparam name_array_t NAME_RST = default_names();
endpackage

// [indicator_status_monitor.sv]
// Indicator status monitor: five position indicators from selectable inputs.
// Assumes pins on I_DI are asynchronous and I_SW comes from the same clock.
`timescale 1ns/1ns
module indicator_status_monitor #(
  parameter int P_STAMP_CYCLES = indicator_status_pkg::STAMP_CYCLES
) (
  input  wire logic                                            I_CLK,
  input  wire logic                                            I_RST_B,
  input  wire logic [indicator_status_pkg::NUM_DI-1:0]         I_DI,
  input  wire logic [indicator_status_pkg::NUM_SW-1:0]         I_SW,
  input  wire logic                                            I_CFG_MODE,
  input  wire logic [indicator_status_pkg::NUM_IND*4-1:0]      I_OPEN_SEL,
  input  wire logic [indicator_status_pkg::NUM_IND*4-1:0]      I_CLOSE_SEL,
  input  wire logic [indicator_status_pkg::NUM_IND-1:0]        I_OPEN_INV,
  input  wire logic [indicator_status_pkg::NUM_IND-1:0]        I_CLOSE_INV,
  input  wire logic [indicator_status_pkg::EVT_W-1:0]          I_KEEP_ON,
  input  wire logic [indicator_status_pkg::EVT_W-1:0]          I_KEEP_OFF,
  input  wire logic                                            I_NAME_WE,
  input  wire logic [indicator_status_pkg::IND_W-1:0]          I_NAME_IND,
  input  wire logic [indicator_status_pkg::POS_W-1:0]          I_NAME_POS,
  input  wire logic [indicator_status_pkg::CHAR_W-1:0]         I_NAME_CHAR,
  output logic [indicator_status_pkg::CHAR_W-1:0]              O_NAME_CHAR,
  output logic [indicator_status_pkg::NUM_IND*2-1:0]           O_IND_STATE,
  output logic [indicator_status_pkg::EVT_W-1:0]               O_STATE_FLAGS,
  output logic                                                 O_EVT_VALID,
  output logic [indicator_status_pkg::EVT_W-1:0]               O_EVT_ON,
  output logic [indicator_status_pkg::EVT_W-1:0]               O_EVT_OFF,
  output logic [indicator_status_pkg::STAMP_W-1:0]             O_EVT_STAMP,
  output logic [indicator_status_pkg::STAMP_W-1:0]             O_TIME_MS
);
  import indicator_status_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [NUM_DI-1:0]             s1;
    logic [NUM_DI-1:0]             s2;
    logic [NUM_DI-1:0]             s3;
    logic [NUM_DI-1:0]             di;
    logic [NUM_IND-1:0][SRC_W-1:0] open_sel;
    logic [NUM_IND-1:0][SRC_W-1:0] close_sel;
    logic [NUM_IND-1:0]            open_inv;
    logic [NUM_IND-1:0]            close_inv;
    logic [EVT_W-1:0]              keep_on;
    logic [EVT_W-1:0]              keep_off;
    logic [EVT_W-1:0]              flags;
    logic                          primed;
    ind_state_t [NUM_IND-1:0]      ind;
    logic [DIV_W-1:0]              div;
    logic [STAMP_W-1:0]            ms;
    logic                          evt_valid;
    logic [EVT_W-1:0]              evt_on;
    logic [EVT_W-1:0]              evt_off;
    logic [STAMP_W-1:0]            evt_stamp;
    name_array_t                   names;
    logic [CHAR_W-1:0]             name_q;
  } state_t;

  state_t                    cur;
  state_t                    next_cur;
  logic [NUM_DI+NUM_SW-1:0]  src;
  logic [NUM_IND-1:0]        raw_open;
  logic [NUM_IND-1:0]        raw_close;
  ind_state_t [NUM_IND-1:0]  eval_state;
  logic [EVT_W-1:0]          eval_flags;
  logic [EVT_W-1:0]          rise;
  logic [EVT_W-1:0]          fall;

  assign src = {I_SW, cur.di};

  // ------------------------------------------------------------
  // Per-indicator evaluation
  // ------------------------------------------------------------
  for (genvar i = 0; i < NUM_IND; i++) begin : g_ind
    // Inversion lets one input drive both status lines
    assign raw_open[i]  = src[cur.open_sel[i]] ^ cur.open_inv[i];
    assign raw_close[i] = src[cur.close_sel[i]] ^ cur.close_inv[i];
    always_comb begin
      case ({raw_open[i], raw_close[i]})
        2'h2:    eval_state[i] = ST_OPEN;
        2'h1:    eval_state[i] = ST_CLOSED;
        2'h3:    eval_state[i] = ST_BAD;
        default: eval_state[i] = ST_INTER;
      endcase
    end
    assign eval_flags[i*KIND_N +: KIND_N] = 4'h1 << eval_state[i];

    open_state_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
      (!I_CFG_MODE && raw_open[i] && !raw_close[i]) |=> cur.ind[i] == ST_OPEN)
      else $error("open input did not give open state");

    close_state_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
      (!I_CFG_MODE && !raw_open[i] && raw_close[i]) |=> cur.ind[i] == ST_CLOSED)
      else $error("close input did not give closed state");

    inter_state_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
      (!I_CFG_MODE && !raw_open[i] && !raw_close[i]) |=> cur.ind[i] == ST_INTER)
      else $error("no input active did not give intermediate");

    bad_state_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
      (!I_CFG_MODE && raw_open[i] && raw_close[i]) |=> cur.ind[i] == ST_BAD)
      else $error("both inputs active did not give bad");

    shared_input_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
      (cur.open_sel[i] == cur.close_sel[i] && cur.open_inv[i] != cur.close_inv[i])
      |-> raw_open[i] != raw_close[i])
      else $error("inverted shared input not complementary");

    one_hot_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
      cur.primed |-> $onehot(cur.flags[i*KIND_N +: KIND_N])
                     && cur.flags[i*KIND_N + int'(cur.ind[i])])
      else $error("state signals not one per indicator");
  end

  assign rise = eval_flags & ~cur.flags & {EVT_W{cur.primed}};
  assign fall = ~eval_flags & cur.flags & {EVT_W{cur.primed}};

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    // Pin synchroniser; a level counts once stages two and three agree
    next_cur.s1 = I_DI;
    next_cur.s2 = cur.s1;
    next_cur.s3 = cur.s2;
    for (int b = 0; b < NUM_DI; b++) begin
      if (cur.s2[b] == cur.s3[b]) begin
        next_cur.di[b] = cur.s3[b];
      end
    end
    // Millisecond time base for stamps
    if (cur.div == DIV_W'(P_STAMP_CYCLES - 1)) begin
      next_cur.div = '0;
      next_cur.ms  = cur.ms + 1'b1;
    end else begin
      next_cur.div = cur.div + 1'b1;
    end
    next_cur.evt_valid = 1'b0;
    next_cur.evt_on    = '0;
    next_cur.evt_off   = '0;
    if (I_CFG_MODE) begin
      // Setup is taken only here and frozen while monitoring runs
      next_cur.open_sel  = I_OPEN_SEL;
      next_cur.close_sel = I_CLOSE_SEL;
      next_cur.open_inv  = I_OPEN_INV;
      next_cur.close_inv = I_CLOSE_INV;
      next_cur.keep_on   = I_KEEP_ON;
      next_cur.keep_off  = I_KEEP_OFF;
      next_cur.primed    = 1'b0;
      if (I_NAME_WE && I_NAME_IND < IND_W'(NUM_IND)) begin
        next_cur.names[I_NAME_IND][I_NAME_POS] = I_NAME_CHAR;
      end
    end else begin
      // First pass after setup only learns the present state
      next_cur.ind    = eval_state;
      next_cur.flags  = eval_flags;
      next_cur.primed = 1'b1;
      next_cur.evt_on    = rise & cur.keep_on;
      next_cur.evt_off   = fall & cur.keep_off;
      next_cur.evt_valid = |((rise & cur.keep_on) | (fall & cur.keep_off));
      // Stamp only moves with an event so it stays readable afterwards
      if (next_cur.evt_valid) begin
        next_cur.evt_stamp = cur.ms;
      end
    end
    if (I_NAME_IND < IND_W'(NUM_IND)) begin
      next_cur.name_q = cur.names[I_NAME_IND][I_NAME_POS];
    end else begin
      next_cur.name_q = '0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cur           <= '0;
      cur.open_sel  <= {NUM_IND{RST_SEL}};
      cur.close_sel <= {NUM_IND{RST_SEL}};
      cur.keep_on   <= RST_KEEP;
      cur.keep_off  <= RST_KEEP;
      cur.names     <= NAME_RST;
    end else begin
      cur <= next_cur;
    end
  end

  // ------------------------------------------------------------
  // Outputs: status, events, time and name read-back only, nothing drives the switch
  // ------------------------------------------------------------
  assign O_IND_STATE   = cur.ind;
  assign O_STATE_FLAGS = cur.flags;
  assign O_EVT_VALID   = cur.evt_valid;
  assign O_EVT_ON      = cur.evt_on;
  assign O_EVT_OFF     = cur.evt_off;
  assign O_EVT_STAMP   = cur.evt_stamp;
  assign O_TIME_MS     = cur.ms;
  assign O_NAME_CHAR   = cur.name_q;

  // ------------------------------------------------------------
  // Checks: events
  // ------------------------------------------------------------
  on_event_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (!I_CFG_MODE && |(rise & cur.keep_on))
    |=> O_EVT_VALID && (O_EVT_ON == $past(rise & cur.keep_on)))
    else $error("on edge not reported");

  off_event_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (!I_CFG_MODE && |(fall & cur.keep_off))
    |=> O_EVT_VALID && (O_EVT_OFF == $past(fall & cur.keep_off)))
    else $error("off edge not reported");

  evt_clear_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !O_EVT_VALID |-> (O_EVT_ON == '0) && (O_EVT_OFF == '0))
    else $error("event bits set without a pulse");

  pulse_content_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_EVT_VALID |-> (O_EVT_ON | O_EVT_OFF) != '0)
    else $error("event pulse carries no edge");

  on_active_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_EVT_VALID |-> (O_EVT_ON & ~O_STATE_FLAGS) == '0)
    else $error("on event for an inactive state");

  off_inactive_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_EVT_VALID |-> (O_EVT_OFF & O_STATE_FLAGS) == '0)
    else $error("off event for an active state");

  edge_filter_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_EVT_VALID |-> ((O_EVT_ON & ~$past(cur.keep_on)) == '0)
                 && ((O_EVT_OFF & ~$past(cur.keep_off)) == '0))
    else $error("unselected edge stored");

  no_repeat_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (!I_CFG_MODE && eval_flags == cur.flags) |=> !O_EVT_VALID)
    else $error("event without a state change");

  prime_quiet_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (!I_CFG_MODE && !cur.primed) |=> !O_EVT_VALID)
    else $error("event on the priming pass");

  prime_learn_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (!I_CFG_MODE && !cur.primed) |=> O_IND_STATE == $past(eval_state))
    else $error("priming pass did not learn the state");

  // ------------------------------------------------------------
  // Checks: time base
  // ------------------------------------------------------------
  stamp_value_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_EVT_VALID |-> O_EVT_STAMP == $past(cur.ms))
    else $error("event stamp not the event time");

  stamp_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !O_EVT_VALID |-> $stable(O_EVT_STAMP))
    else $error("event stamp moved without an event");

  ms_tick_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (cur.div == DIV_W'(P_STAMP_CYCLES - 1)) |=> O_TIME_MS == $past(cur.ms) + 1'b1)
    else $error("millisecond count did not advance");

  ms_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (cur.div != DIV_W'(P_STAMP_CYCLES - 1)) |=> $stable(O_TIME_MS))
    else $error("millisecond count moved early");

  div_range_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    cur.div <= DIV_W'(P_STAMP_CYCLES - 1))
    else $error("millisecond divider out of range");

  // ------------------------------------------------------------
  // Checks: setup and names
  // ------------------------------------------------------------
  cfg_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !$past(I_CFG_MODE) |-> $stable(cur.open_sel) && $stable(cur.keep_on))
    else $error("setup changed while monitoring");

  inv_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !$past(I_CFG_MODE) |-> $stable(cur.open_inv) && $stable(cur.close_inv)
                        && $stable(cur.close_sel) && $stable(cur.keep_off))
    else $error("inversion or close setup changed while monitoring");

  sel_load_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_CFG_MODE |=> (cur.open_sel == $past(I_OPEN_SEL))
               && (cur.close_sel == $past(I_CLOSE_SEL)))
    else $error("selection not taken in configuration");

  keep_load_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_CFG_MODE |=> (cur.keep_on == $past(I_KEEP_ON))
               && (cur.keep_off == $past(I_KEEP_OFF)))
    else $error("edge selection not taken in configuration");

  cfg_freeze_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_CFG_MODE |=> $stable(O_IND_STATE) && $stable(O_STATE_FLAGS))
    else $error("state moved during configuration");

  cfg_no_event_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_CFG_MODE |=> !O_EVT_VALID)
    else $error("event during configuration");

  name_write_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (I_CFG_MODE && I_NAME_WE && I_NAME_IND < IND_W'(NUM_IND))
    |=> cur.names[$past(I_NAME_IND)][$past(I_NAME_POS)] == $past(I_NAME_CHAR))
    else $error("name character not stored");

  name_keep_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !I_CFG_MODE |=> $stable(cur.names))
    else $error("name changed while monitoring");

  name_read_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    (I_NAME_IND >= IND_W'(NUM_IND)) |=> O_NAME_CHAR == '0)
    else $error("name read outside indicators not zero");
endmodule

// [aux_contact_model.sv]
// Auxiliary contact model: switch contacts wired to the monitor's pin inputs.
// Assumes the bench sets the wanted contact levels; slow mode adds travel time.
`timescale 1ns/1ns
module aux_contact_model #(
  parameter int TRAVEL = 4
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic [7:0] i_pos,
  input  wire logic       i_slow,
  output logic      [7:0] o_di
);
  int cnt;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_di <= 8'h00;
      cnt <= 0;
    end else if (o_di == i_pos) begin
      cnt <= 0;
    end else if (!i_slow || cnt == TRAVEL) begin
      o_di <= i_pos;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// [tb.sv]
// Testbench of the indicator status monitor: setup, monitoring, events, names.
// Assumes the monitor package, the monitor and the contact model compile first.
`timescale 1ns/1ns
module tb;
  import indicator_status_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, cfg = 1'b1, nwe = 1'b0, slow = 1'b0;
  logic [7:0]  pos = 8'h00, sw = 8'h00, nchr = 8'h00, di, name_q;
  logic [19:0] osel = 20'h0ECA8, csel = 20'h0FDB9, kon = 20'hFFFFF, koff = 20'hFFFFF;
  logic [2:0]  nind = 3'h0;
  logic [4:0]  npos = 5'h00;
  logic [4:0]  oinv = 5'h00, cinv = 5'h10;
  logic [9:0]  state_q, cur = 10'h000;
  logic [19:0] flags_q, on_q, off_q;
  logic        valid_q;
  logic [31:0] stamp_q, time_q;
  int          errors = 0, compares = 0;
  always #5 clk = ~clk;
  indicator_status_monitor #(.P_STAMP_CYCLES(10)) i_indicator_status_monitor (
    .I_CLK(clk), .I_RST_B(rst_b), .I_DI(di), .I_SW(sw), .I_CFG_MODE(cfg),
    .I_OPEN_SEL(osel), .I_CLOSE_SEL(csel), .I_OPEN_INV(oinv), .I_CLOSE_INV(cinv),
    .I_KEEP_ON(kon), .I_KEEP_OFF(koff), .I_NAME_WE(nwe), .I_NAME_IND(nind),
    .I_NAME_POS(npos), .I_NAME_CHAR(nchr), .O_NAME_CHAR(name_q), .O_IND_STATE(state_q),
    .O_STATE_FLAGS(flags_q), .O_EVT_VALID(valid_q), .O_EVT_ON(on_q), .O_EVT_OFF(off_q),
    .O_EVT_STAMP(stamp_q), .O_TIME_MS(time_q));
  aux_contact_model i_aux_contact_model (
    .i_clk(clk), .i_rst_b(rst_b), .i_pos(pos), .i_slow(slow), .o_di(di));
  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude();
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic name_wr(input logic [2:0] ind, input logic [4:0] p, input logic [7:0] c);
    @(negedge clk);
    nind = ind;
    npos = p;
    nchr = c;
    nwe = 1'b1;
    @(negedge clk);
    nwe = 1'b0;
  endtask
  task automatic name_rd(input logic [2:0] ind, input logic [4:0] p, input logic [7:0] e);
    @(negedge clk);
    nind = ind;
    npos = p;
    repeat (2) @(posedge clk);
    #1 chk(name_q, e, "name");
  endtask
  // Sets sources, collects event pulses over a window, checks state and events
  task automatic step(input logic [7:0] s, input logic [7:0] p, input bit quiet);
    logic [9:0]  nx;
    logic [19:0] eon, eoff, ef, gon, goff;
    int          n;
    nx = cfg ? cur : {p[0] ^ cinv[4], p[0] ^ oinv[4], s};
    eon = '0;
    eoff = '0;
    ef = '0;
    gon = '0;
    goff = '0;
    n = 0;
    for (int i = 0; i < 5; i++) begin
      ef[4*i+nx[2*i+:2]] = 1'b1;
      if (nx[2*i+:2] != cur[2*i+:2] && !quiet) begin
        eon[4*i+nx[2*i+:2]]   = kon[4*i+nx[2*i+:2]];
        eoff[4*i+cur[2*i+:2]] = koff[4*i+cur[2*i+:2]];
      end
    end
    @(negedge clk);
    sw = s;
    pos = p;
    repeat (14) begin
      @(posedge clk);
      #1;
      if (valid_q === 1'b1) begin
        n++;
        gon |= on_q;
        goff |= off_q;
        chk(32'(time_q - stamp_q <= 32'h1), 1, "stamp");
      end
    end
    chk(state_q, nx, "state");
    chk(flags_q, ef, "flags");
    chk(gon, eon, "on");
    chk(goff, eoff, "off");
    chk(n, 32'((eon | eoff) != 0), "pulses");
    cur = nx;
  endtask
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] t;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    chk(state_q, 0, "reset state");
    name_rd(0, 0, 8'h49);
    name_rd(0, 3, 8'h31);
    name_rd(4, 3, 8'h35);
    name_rd(4, 4, 8'h00);
    name_wr(2, 31, 8'h5A);
    name_rd(2, 31, 8'h5A);
    name_wr(5, 0, 8'h41);
    name_rd(0, 0, 8'h49);
    $display("Test reset and names done");
    @(negedge clk);
    cfg = 1'b0;
    step(8'h00, 8'h00, 1);
    name_wr(2, 31, 8'h41);
    name_rd(2, 31, 8'h5A);
    step(8'h01, 8'h00, 0);
    step(8'h02, 8'h00, 0);
    step(8'h03, 8'h00, 0);
    step(8'h00, 8'h00, 0);
    step(8'h00, 8'h00, 0);
    step(8'hE4, 8'h00, 0);
    $display("Test states done");
    step(8'hE4, 8'h01, 0);
    slow = 1'b1;
    step(8'hE4, 8'h00, 0);
    $display("Test shared pin done");
    @(negedge clk);
    osel = 20'h0ECA9;
    step(8'hE5, 8'h00, 0);
    @(negedge clk);
    t = time_q;
    repeat (10) @(posedge clk);
    #1 chk(time_q - t, 1, "ms");
    $display("Test frozen setup and time done");
    @(negedge clk);
    cfg = 1'b1;
    kon = 20'h0000F;
    koff = 20'hFFFF0;
    osel = 20'h0ECA8;
    oinv = 5'h10;
    cinv = 5'h00;
    step(8'h00, 8'h00, 1);
    @(negedge clk);
    cfg = 1'b0;
    step(8'h00, 8'h00, 1);
    step(8'h55, 8'h00, 0);
    step(8'h00, 8'h00, 0);
    step(8'h00, 8'h01, 0);
    $display("Test edge selection done");
    conclude();
  end
endmodule
